// ---- cct_consts.vh ----
`ifndef CCT_CONSTS_VH
`define CCT_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define CCT_IDX_CTRL    16'hffb6
`define CCT_IDX_STAT    16'hffb7
`define CCT_IDX_CNT_H   16'hffb8
`define CCT_IDX_CNT_L   16'hffb9
`define CCT_IDX_CMP_H   16'hffba
`define CCT_IDX_CMP_L   16'hffbb
`define CCT_IDX_IRQ_REQ 16'hffc0
`define CCT_IDX_IRQ_EN  16'hffc1
`define CCT_IDX_CLKSTP  16'hfffa

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CCT_RST_CTRL    8'h00
`define CCT_RST_STAT    8'h00
`define CCT_RST_CNT     8'h00
`define CCT_RST_CMP     8'hff
`define CCT_RST_CLKSTP  8'hff
`define CCT_BYTE_MAX    8'hff
`define CCT_BYTE_ZERO   8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCT_CTRL_TOL_H  7
`define CCT_CTRL_WIDTH  6
`define CCT_CTRL_CKS_H1 5
`define CCT_CTRL_CKS_H0 4
`define CCT_CTRL_TOL_L  3
`define CCT_CTRL_CKS_L2 2
`define CCT_CTRL_CKS_L0 0
`define CCT_ST_OVF_H    7
`define CCT_ST_OVIE_H   6
`define CCT_ST_CMF_H    5
`define CCT_ST_CCLR_H   4
`define CCT_ST_OVF_L    3
`define CCT_ST_OVIE_L   2
`define CCT_ST_CMF_L    1
`define CCT_ST_CCLR_L   0
`define CCT_ST_FLAGS    8'haa
`define CCT_IRQ_H       1
`define CCT_IRQ_L       0
`define CCT_CLKSTP_RUN  2

// ----------------------------------------------------------------------
// Clock source codes (two low select bits)
// ----------------------------------------------------------------------
`define CCT_SRC_DIV32   2'h0
`define CCT_SRC_DIV16   2'h1
`define CCT_SRC_DIV4    2'h2
`define CCT_SRC_SUB4    2'h3
`define CCT_PRE_MAX32   5'h1f
`define CCT_PRE_MAX16   4'hf
`define CCT_PRE_MAX4    2'h3
`define CCT_SUB_MAX     2'h3

`endif

// ---- cct_timer.v ----
`timescale 1ns/10ps
`include "cct_consts.vh"

// Behaviour
// [RULE1] Width-select 0: both byte counters form one 16-bit up-counter, high on top.
// [RULE2] In 16-bit mode the low clock select field clocks the whole counter.
// [RULE3] In 16-bit mode high clear-on-match clears the whole counter on match.
// [RULE4] 16-bit wrap sets high overflow flag; with enable, high irq request too.
// [RULE5] Width-select 1: the two byte counters run independently.
// [RULE6] In 8-bit mode each byte counter uses its own clock select field.
// [RULE7] In 8-bit mode each byte clears on its own match if enabled.
// [RULE8] 8-bit wrap sets that channel's overflow flag, and irq request if enabled.
// [RULE9] In 16-bit mode counter and compare bytes pass through a temporary byte.
// [RULE10] Reset clears both counter bytes to zero.
// [RULE11] Reset loads both compare bytes with all ones.
// [RULE12] 16-bit equality sets high match flag and high irq request together.
// [RULE13] In 16-bit mode matches toggle the high pin; level presettable.
// [RULE14] In 8-bit mode each byte compares separately and sets its own flags.
// [RULE15] In 8-bit mode each pin toggles on its own channel's matches.
// [RULE16] Control register: 8-bit write-only, reset zero, documented field layout.
// [RULE17] Writing the high toggle-level bit sets the high pin at once.
// [RULE18] 8-bit high select: 00 /32, 01 /16, 10 /4, 11 subclock/4.
// [RULE19] Low select 000 counts edges of the external event input pin.
// [RULE20] Each match with toggle output inverts the pin's current level.
module cct_timer #(
   parameter ADDR_W = 18
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire event_input_pin,
   input wire subclock_pin,
   output reg high_toggle_pin,
   output reg low_toggle_pin,
   output reg high_irq,
   output reg low_irq
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg [7:0] timer_control;
   reg [7:0] timer_control_status;
   reg [7:0] counter_high_byte;
   reg [7:0] counter_low_byte;
   reg [7:0] compare_high_byte;
   reg [7:0] compare_low_byte;
   reg [7:0] module_clock_stop;
   reg [1:0] irq_request;
   reg [1:0] irq_enable;
   // Holding byte for wide accesses
   reg [7:0] temp_byte;
   // Prescaler and subclock divider
   reg [4:0] prescale;
   reg [1:0] sub_div;
   // Synchronisers and match history
   reg ev_s1, ev_s2, ev_s3;
   reg sub_s1, sub_s2, sub_s3;
   reg eq_h_q, eq_l_q, eq_16_q;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   // Word index; byte lanes are not decoded
   wire [15:0] idx = paddr[ADDR_W-1:2];
   wire aligned = (paddr[1:0] == 2'h0);
   // Misaligned addresses hit nothing
   wire hit_ctrl = aligned && (idx == `CCT_IDX_CTRL);
   wire hit_stat = aligned && (idx == `CCT_IDX_STAT);
   wire hit_cnt_h = aligned && (idx == `CCT_IDX_CNT_H);
   wire hit_cnt_l = aligned && (idx == `CCT_IDX_CNT_L);
   wire hit_cmp_h = aligned && (idx == `CCT_IDX_CMP_H);
   wire hit_cmp_l = aligned && (idx == `CCT_IDX_CMP_L);
   wire hit_ireq = aligned && (idx == `CCT_IDX_IRQ_REQ);
   wire hit_ien = aligned && (idx == `CCT_IDX_IRQ_EN);
   wire hit_stp = aligned && (idx == `CCT_IDX_CLKSTP);
   wire hit_any = hit_ctrl | hit_stat | hit_cnt_h | hit_cnt_l | hit_cmp_h |
                  hit_cmp_l | hit_ireq | hit_ien | hit_stp;
   // Side effects only on the access edge
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite & ~pslverr;
   wire rd = access & ~pwrite & ~pslverr;
   // Only the low write byte is used
   wire [7:0] wbyte = pwdata[7:0];

   // ----------------------------------------------------------------------
   // Mode and control fields
   // ----------------------------------------------------------------------
   // Write-only control fields
   wire split = timer_control[`CCT_CTRL_WIDTH];
   wire [1:0] sel_h = timer_control[`CCT_CTRL_CKS_H1:`CCT_CTRL_CKS_H0];
   wire [2:0] sel_l = timer_control[`CCT_CTRL_CKS_L2:`CCT_CTRL_CKS_L0];
   // Module stop gates every source
   wire running = module_clock_stop[`CCT_CLKSTP_RUN];
   // Status control bits
   wire clr_h = timer_control_status[`CCT_ST_CCLR_H];
   wire clr_l = timer_control_status[`CCT_ST_CCLR_L];
   wire ovie_h = timer_control_status[`CCT_ST_OVIE_H];
   wire ovie_l = timer_control_status[`CCT_ST_OVIE_L];

   // ----------------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------------
   // Prescaler taps; edge detects compare the second and third sync stages
   wire t32 = (prescale == `CCT_PRE_MAX32);
   wire t16 = (prescale[3:0] == `CCT_PRE_MAX16);
   wire t4 = (prescale[1:0] == `CCT_PRE_MAX4);
   // Subclock divided by four
   wire sub_rise = sub_s2 & ~sub_s3;
   wire tsub = sub_rise && (sub_div == `CCT_SUB_MAX);
   // Falling event edges are ignored
   wire ev_rise = ev_s2 & ~ev_s3;

   // Internal source picked by a two-bit code
   function src_tick;
      input [1:0] code;
      input a, b, c, d;
      begin
         case (code)
            `CCT_SRC_DIV32: src_tick = a;
            `CCT_SRC_DIV16: src_tick = b;
            `CCT_SRC_DIV4: src_tick = c;
            default: src_tick = d;
         endcase
      end
   endfunction

   // Low select with top bit 0 means event input; codes 001..011 never tick
   wire sel_l_tick = sel_l[2] ? src_tick(sel_l[1:0], t32, t16, t4, tsub) :
                     (sel_l[1:0] == 2'h0) & ev_rise; // [RULE19]
   wire tick_l = running & sel_l_tick; // [RULE2] [RULE6]
   // Full flags feed carry and overflow
   wire low_full = (counter_low_byte == `CCT_BYTE_MAX);
   wire high_full = (counter_high_byte == `CCT_BYTE_MAX);
   // High byte follows the low carry when cascaded
   wire tick_h = split ? running & src_tick(sel_h, t32, t16, t4, tsub) :
                 tick_l & low_full; // [RULE1] [RULE18]

   // ----------------------------------------------------------------------
   // Compare
   // ----------------------------------------------------------------------
   // Match is the rising edge of equality so a stopped counter fires once
   wire eq_h = (counter_high_byte == compare_high_byte);
   wire eq_l = (counter_low_byte == compare_low_byte);
   wire eq_16 = eq_h & eq_l;
   wire m16 = ~split & eq_16 & ~eq_16_q; // [RULE12]
   wire m_h = split ? (eq_h & ~eq_h_q) : m16; // [RULE14]
   wire m_l = split & eq_l & ~eq_l_q; // [RULE14]
   // Clear happens on the next count tick while equal
   wire clr16 = ~split & clr_h & eq_16 & tick_l; // [RULE3]
   wire clr8_h = split & clr_h & eq_h & tick_h; // [RULE7]
   wire clr8_l = split & clr_l & eq_l & tick_l; // [RULE7]
   // A clear beats a wrap: no overflow
   wire ovf16 = ~split & tick_l & low_full & high_full & ~clr16; // [RULE4]
   wire ovf8_h = split & tick_h & high_full & ~clr8_h; // [RULE8]
   wire ovf8_l = split & tick_l & low_full & ~clr8_l; // [RULE8]
   // Shared by high channel and wide mode
   wire ovf_h_ev = ovf16 | ovf8_h;

   // ----------------------------------------------------------------------
   // Synchronisers and prescaler
   // ----------------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_s1 <= 1'b0;
         ev_s2 <= 1'b0;
         ev_s3 <= 1'b0;
         sub_s1 <= 1'b0;
         sub_s2 <= 1'b0;
         sub_s3 <= 1'b0;
         prescale <= 5'h00;
         sub_div <= 2'h0;
         eq_h_q <= 1'b1;
         eq_l_q <= 1'b1;
         eq_16_q <= 1'b1;
      end else begin
         ev_s1 <= event_input_pin;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         sub_s1 <= subclock_pin;
         sub_s2 <= sub_s1;
         sub_s3 <= sub_s2;
         // Free-running prescaler
         prescale <= prescale + 5'h01;
         if (sub_rise) begin
            sub_div <= sub_div + 2'h1;
         end
         // History for the match edge detect
         eq_h_q <= eq_h;
         eq_l_q <= eq_l;
         eq_16_q <= eq_16;
      end
   end

   // ----------------------------------------------------------------------
   // Counters, compare bytes and temporary byte
   // ----------------------------------------------------------------------
   // Bus writes beat counting. In 16-bit mode a high byte write parks in
   // the temporary byte and lands with the low byte write; a high byte
   // read snapshots the low byte so the pair reads coherently.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_high_byte <= `CCT_RST_CNT; // [RULE10]
         counter_low_byte <= `CCT_RST_CNT; // [RULE10]
         compare_high_byte <= `CCT_RST_CMP; // [RULE11]
         compare_low_byte <= `CCT_RST_CMP; // [RULE11]
         temp_byte <= `CCT_BYTE_ZERO;
      end else begin
         // High counter byte
         if (wr && hit_cnt_h && split) begin
            counter_high_byte <= wbyte;
         end else if (wr && hit_cnt_l && !split) begin
            counter_high_byte <= temp_byte; // [RULE9]
         end else if (clr16 || clr8_h) begin
            counter_high_byte <= `CCT_BYTE_ZERO;
         end else if (tick_h) begin
            counter_high_byte <= counter_high_byte + 8'h01; // [RULE5]
         end
         // Low counter byte
         if (wr && hit_cnt_l) begin
            counter_low_byte <= wbyte;
         end else if (clr16 || clr8_l) begin
            counter_low_byte <= `CCT_BYTE_ZERO;
         end else if (tick_l) begin
            counter_low_byte <= counter_low_byte + 8'h01;
         end
         // Compare bytes
         if (wr && hit_cmp_h && split) begin
            compare_high_byte <= wbyte;
         end else if (wr && hit_cmp_l && !split) begin
            compare_high_byte <= temp_byte; // [RULE9]
         end
         if (wr && hit_cmp_l) begin
            compare_low_byte <= wbyte;
         end
         // Temporary byte
         if (!split && wr && (hit_cnt_h || hit_cmp_h)) begin
            temp_byte <= wbyte; // [RULE9]
         end else if (!split && rd && hit_cnt_h) begin
            temp_byte <= counter_low_byte; // [RULE9]
         end else if (!split && rd && hit_cmp_h) begin
            temp_byte <= compare_low_byte; // [RULE9]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Control, status, interrupt request and pins
   // ----------------------------------------------------------------------
   // Hardware set wins over a software write of zero in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_control <= `CCT_RST_CTRL; // [RULE16]
         timer_control_status <= `CCT_RST_STAT;
         module_clock_stop <= `CCT_RST_CLKSTP;
         irq_request <= 2'h0;
         irq_enable <= 2'h0;
         high_toggle_pin <= 1'b0;
         low_toggle_pin <= 1'b0;
         high_irq <= 1'b0;
         low_irq <= 1'b0;
      end else begin
         // Control register
         if (wr && hit_ctrl) begin
            timer_control <= wbyte; // [RULE16]
         end
         // Module stop register
         if (wr && hit_stp) begin
            module_clock_stop <= wbyte;
         end
         // Interrupt enables
         if (wr && hit_ien) begin
            irq_enable <= pwdata[1:0];
         end
         // Status: flags clear by writing 0, controls plain read/write
         if (wr && hit_stat) begin
            timer_control_status <= wbyte & timer_control_status |
               wbyte & ~`CCT_ST_FLAGS;
         end
         if (ovf_h_ev) begin
            timer_control_status[`CCT_ST_OVF_H] <= 1'b1; // [RULE4] [RULE8]
         end
         if (ovf8_l) begin
            timer_control_status[`CCT_ST_OVF_L] <= 1'b1; // [RULE8]
         end
         if (m_h) begin
            timer_control_status[`CCT_ST_CMF_H] <= 1'b1; // [RULE12] [RULE14]
         end
         if (m_l) begin
            timer_control_status[`CCT_ST_CMF_L] <= 1'b1; // [RULE14]
         end
         // Interrupt request flags
         if (wr && hit_ireq) begin
            irq_request <= irq_request & pwdata[1:0];
         end
         if (m_h || (ovf_h_ev && ovie_h)) begin
            irq_request[`CCT_IRQ_H] <= 1'b1; // [RULE4] [RULE12]
         end
         if (m_l || (ovf8_l && ovie_l)) begin
            irq_request[`CCT_IRQ_L] <= 1'b1; // [RULE8] [RULE14]
         end
         // Requests are registered outputs
         high_irq <= irq_request[`CCT_IRQ_H] & irq_enable[`CCT_IRQ_H];
         low_irq <= irq_request[`CCT_IRQ_L] & irq_enable[`CCT_IRQ_L];
         // Pins: a control write presets, a match inverts
         if (wr && hit_ctrl) begin
            high_toggle_pin <= wbyte[`CCT_CTRL_TOL_H]; // [RULE17]
            low_toggle_pin <= wbyte[`CCT_CTRL_TOL_L];
         end else begin
            if (m_h) begin
               high_toggle_pin <= ~high_toggle_pin; // [RULE13] [RULE20]
            end
            if (m_l) begin
               low_toggle_pin <= ~low_toggle_pin; // [RULE15] [RULE20]
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   // Read data is captured in setup so every output is a flip-flop; the
   // access phase therefore always completes with no wait state. The
   // temporary byte is read for the low byte in 16-bit mode.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Zero wait states
         pready <= setup;
         pslverr <= setup & ~hit_any;
         if (setup && !pwrite) begin
            // Unmapped and write-only read zero
            prdata <= 32'h00000000;
            if (hit_stat) begin
               prdata[7:0] <= timer_control_status;
            end
            if (hit_cnt_h) begin
               prdata[7:0] <= counter_high_byte;
            end
            if (hit_cnt_l) begin
               prdata[7:0] <= split ? counter_low_byte : temp_byte;
            end
            if (hit_cmp_h) begin
               prdata[7:0] <= compare_high_byte;
            end
            if (hit_cmp_l) begin
               prdata[7:0] <= split ? compare_low_byte : temp_byte;
            end
            if (hit_ireq) begin
               prdata[1:0] <= irq_request;
            end
            if (hit_ien) begin
               prdata[1:0] <= irq_enable;
            end
            if (hit_stp) begin
               prdata[7:0] <= module_clock_stop;
            end
         end
      end
   end

endmodule // cct_timer

// ---- cct_props.sv ----
`timescale 1ns/10ps
`include "cct_consts.vh"
module cct_props #(
   parameter ADDR_W = 18
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire event_input_pin,
   input wire subclock_pin,
   input wire high_toggle_pin,
   input wire low_toggle_pin,
   input wire high_irq,
   input wire low_irq
);
   wire acc = psel && penable && pready;
   wire ctrl_hit = paddr == {`CCT_IDX_CTRL, 2'b00};
   wire ctrl_wr = acc && pwrite && ctrl_hit;
   wire en_wr = acc && pwrite && paddr == {`CCT_IDX_IRQ_EN, 2'b00};
   reg mode8;
   reg en_h;
   reg en_l;
   // Shadows of write-only mode bit and irq enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode8 <= 1'b0;
         en_h <= 1'b0;
         en_l <= 1'b0;
      end else begin
         if (ctrl_wr)
            mode8 <= pwdata[`CCT_CTRL_WIDTH];
         if (en_wr) begin
            en_h <= pwdata[1];
            en_l <= pwdata[0];
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer timing and refusals
   chk_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   chk_err_unaligned: assert property (
      psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("unaligned access not refused");
   chk_ctrl_reads_zero: assert property (
      acc && !pwrite && ctrl_hit |-> prdata == 32'h0 && !pslverr)
      else $error("control read not zero");
   chk_upper_zero: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read upper bits not zero");
   // Pin presets take effect right after the control write
   chk_high_preset: assert property (
      ctrl_wr |=> high_toggle_pin == $past(pwdata[7]))
      else $error("high pin preset wrong");
   chk_low_preset: assert property (
      ctrl_wr |=> low_toggle_pin == $past(pwdata[3]))
      else $error("low pin preset wrong");
   chk_low_quiet_wide: assert property (
      !mode8 && !ctrl_wr |=> $stable(low_toggle_pin))
      else $error("low pin moved in wide mode");
   // A toggle is a match, and a match raises the request
   chk_high_match_irq: assert property (
      $changed(high_toggle_pin) && !$past(ctrl_wr) && en_h
      |-> ##[0:2] high_irq)
      else $error("high match without irq");
   chk_low_match_irq: assert property (
      $changed(low_toggle_pin) && !$past(ctrl_wr) && en_l
      |-> ##[0:2] low_irq)
      else $error("low match without irq");
endmodule // cct_props

bind cct_timer cct_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .event_input_pin(event_input_pin),
   .subclock_pin(subclock_pin), .high_toggle_pin(high_toggle_pin),
   .low_toggle_pin(low_toggle_pin), .high_irq(high_irq),
   .low_irq(low_irq));

// ---- cct_cpu_model.sv ----
`timescale 1ns/10ps
module cct_cpu_model (
   input wire pclk,
   output reg psel = 1'b0,
   output reg penable = 1'b0,
   output reg pwrite = 1'b0,
   output reg [17:0] paddr = 18'h00000,
   output reg [31:0] pwdata = 32'h00000000,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   // One bus transfer; waits for ready with no assumed latency
   task xfer(input w, input [17:0] a, input [7:0] d,
      output [31:0] rd, output err);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h000000, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         // Released lines scrambled so stale values cannot pass
         paddr <= ~a;
         pwdata <= ~pwdata;
      end
   endtask
endmodule // cct_cpu_model

// ---- cct_tb.sv ----
`timescale 1ns/10ps
`include "cct_consts.vh"
module tb;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg event_input_pin = 1'b0;
   reg subclock_pin = 1'b0;
   wire psel, penable, pwrite, pready, pslverr;
   wire [17:0] paddr;
   wire [31:0] pwdata, prdata;
   wire high_toggle_pin, low_toggle_pin, high_irq, low_irq;
   integer errors = 0;
   integer compares = 0;
   integer cycles = 0;
   integer k;
   integer n;
   reg [31:0] rd;
   reg err;
   cct_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   cct_timer #(.ADDR_W(18)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_input_pin(event_input_pin),
      .subclock_pin(subclock_pin), .high_toggle_pin(high_toggle_pin),
      .low_toggle_pin(low_toggle_pin), .high_irq(high_irq),
      .low_irq(low_irq));
   // Clocks: subclock deliberately unrelated to pclk
   always #5 pclk = ~pclk;
   always #37 subclock_pin = ~subclock_pin;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [15:0] i, input [7:0] d);
      cpu.xfer(1'b1, {i, 2'b00}, d, rd, err);
   endtask
   task rdc(input [15:0] i, input [31:0] exp);
      begin
         cpu.xfer(1'b0, {i, 2'b00}, 8'h00, rd, err);
         chk(rd, exp);
      end
   endtask
   // Event pulses long enough for the input synchroniser
   task ev(input integer cnt);
      repeat (cnt) begin
         @(posedge pclk);
         event_input_pin <= 1'b1;
         repeat (3) @(posedge pclk);
         event_input_pin <= 1'b0;
         repeat (6) @(posedge pclk);
      end
   endtask
   task t_reset;
      begin
         chk({high_toggle_pin, low_toggle_pin, high_irq, low_irq}, 0);
         rdc(`CCT_IDX_CTRL, 32'h0);
         rdc(`CCT_IDX_STAT, 32'h0);
         rdc(`CCT_IDX_CNT_H, 32'h0);
         rdc(`CCT_IDX_CNT_L, 32'h0);
         rdc(`CCT_IDX_CMP_H, 32'hff);
         rdc(`CCT_IDX_CMP_L, 32'hff);
         rdc(`CCT_IDX_CLKSTP, 32'hff);
         cpu.xfer(1'b0, 18'h00100, 8'h00, rd, err);
         chk(err, 1);
         cpu.xfer(1'b1, {`CCT_IDX_CTRL, 2'b01}, 8'h80, rd, err);
         @(negedge pclk);
         chk({err, high_toggle_pin}, 32'h2);
         $display("t_reset done");
      end
   endtask
   task t_preset;
      for (k = 0; k < 4; k = k + 1) begin
         wr(`CCT_IDX_CTRL, {k[1], 3'h0, k[0], 3'h0});
         @(negedge pclk);
         chk({high_toggle_pin, low_toggle_pin}, k);
      end
      $display("t_preset done");
   endtask
   // Low byte as event counter: wrap, then match with clear
   task t_low8;
      begin
         wr(`CCT_IDX_CTRL, 8'h48);
         wr(`CCT_IDX_IRQ_EN, 8'h01);
         wr(`CCT_IDX_STAT, 8'h05);
         wr(`CCT_IDX_CMP_L, 8'h02);
         wr(`CCT_IDX_CNT_L, 8'hfe);
         ev(2);
         rdc(`CCT_IDX_STAT, 32'h0d);
         chk(low_irq, 1);
         wr(`CCT_IDX_IRQ_REQ, 8'h00);
         wr(`CCT_IDX_STAT, 8'h05);
         ev(2);
         chk({low_toggle_pin, low_irq}, 32'h1);
         rdc(`CCT_IDX_STAT, 32'h07);
         ev(1);
         rdc(`CCT_IDX_CNT_L, 32'h0);
         rdc(`CCT_IDX_STAT, 32'h07);
         $display("t_low8 done");
      end
   endtask
   // High byte on each internal source, about four ticks each
   task t_prescale;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            n = (k == 0) ? 128 : (k == 1) ? 64 : (k == 2) ? 16 : 118;
            wr(`CCT_IDX_CTRL, {2'b01, k[1:0], 4'h0});
            wr(`CCT_IDX_CNT_H, 8'h00);
            repeat (n) @(posedge pclk);
            cpu.xfer(1'b0, {`CCT_IDX_CNT_H, 2'b00}, 8'h00, rd, err);
            chk(err, 0);
            chk(rd[7:0] >= 8'h03 && rd[7:0] <= 8'h05, 1);
         end
         rdc(`CCT_IDX_CNT_L, 32'h0);
         $display("t_prescale done");
      end
   endtask
   // Low code 001 never ticks, then halt and resume on /4
   task t_hold;
      begin
         wr(`CCT_IDX_CTRL, 8'h41);
         wr(`CCT_IDX_CNT_L, 8'h10);
         ev(2);
         rdc(`CCT_IDX_CNT_L, 32'h10);
         wr(`CCT_IDX_CLKSTP, 8'hfb);
         wr(`CCT_IDX_CTRL, 8'h46);
         repeat (16) @(posedge pclk);
         rdc(`CCT_IDX_CNT_L, 32'h10);
         wr(`CCT_IDX_CLKSTP, 8'hff);
         repeat (16) @(posedge pclk);
         cpu.xfer(1'b0, {`CCT_IDX_CNT_L, 2'b00}, 8'h00, rd, err);
         chk(rd[7:0] >= 8'h13 && rd[7:0] <= 8'h16, 1);
         $display("t_hold done");
      end
   endtask
   // High byte alone on /4: wrap, match, clear
   task t_high8;
      begin
         wr(`CCT_IDX_CTRL, 8'h60);
         wr(`CCT_IDX_STAT, 8'h50);
         wr(`CCT_IDX_CMP_H, 8'h01);
         wr(`CCT_IDX_CNT_H, 8'hfe);
         repeat (40) @(posedge pclk);
         rdc(`CCT_IDX_STAT, 32'hf0);
         cpu.xfer(1'b0, {`CCT_IDX_CNT_H, 2'b00}, 8'h00, rd, err);
         chk(rd[7:0] <= 8'h01, 1);
         $display("t_high8 done");
      end
   endtask
   // Wide mode: high byte written first, low byte commits the pair
   task t_wide16;
      begin
         wr(`CCT_IDX_CTRL, 8'h00);
         wr(`CCT_IDX_STAT, 8'h50);
         wr(`CCT_IDX_IRQ_REQ, 8'h00);
         wr(`CCT_IDX_IRQ_EN, 8'h02);
         wr(`CCT_IDX_CMP_H, 8'h00);
         wr(`CCT_IDX_CMP_L, 8'h02);
         wr(`CCT_IDX_CNT_H, 8'hff);
         wr(`CCT_IDX_CNT_L, 8'hfe);
         ev(2);
         rdc(`CCT_IDX_STAT, 32'hd0);
         chk(high_irq, 1);
         rdc(`CCT_IDX_CNT_H, 32'h0);
         rdc(`CCT_IDX_CNT_L, 32'h0);
         wr(`CCT_IDX_IRQ_REQ, 8'h00);
         wr(`CCT_IDX_STAT, 8'h50);
         ev(2);
         chk({high_toggle_pin, high_irq}, 32'h3);
         rdc(`CCT_IDX_STAT, 32'h70);
         ev(1);
         rdc(`CCT_IDX_CNT_H, 32'h0);
         rdc(`CCT_IDX_CNT_L, 32'h0);
         wr(`CCT_IDX_CNT_H, 8'h00);
         wr(`CCT_IDX_CNT_L, 8'hff);
         ev(1);
         rdc(`CCT_IDX_CNT_H, 32'h1);
         rdc(`CCT_IDX_CNT_L, 32'h0);
         $display("t_wide16 done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // Hang guard, well above the expected run length
   always @(posedge pclk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_preset;
      t_low8;
      t_prescale;
      t_hold;
      t_high8;
      t_wide16;
      tally_and_finish;
   end
endmodule // tb
